// file: scs_fifo.sv
// Purpose: synchronous FIFO used for transmit and receive words
// Assumes: DEPTH is a power of two; push when full and pop when empty are ignored
// Notes: rdata shows the oldest word combinationally
`timescale 1ns/1ps
`default_nettype none
module scs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// storage side of the bundle
	scs_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_push;
	logic do_pop;

	assign do_push = f.push && (count != (AW+1)'(DEPTH));
	assign do_pop = f.pop && (count != '0);
	assign f.rdata = mem[rd_ptr];
	assign f.full = (count == (AW+1)'(DEPTH));
	assign f.empty = (count == '0);
	assign f.count = count;

	always_ff @(posedge hclk) begin
		if (do_push) begin
			mem[wr_ptr] <= f.wdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	chk_pop_oldest: assert property ((f.pop && !f.empty && !f.push) |=> count == $past(count) - 1'b1) // RULE_12
		else $error("pop did not remove one word");
endmodule : scs_fifo
`default_nettype wire

// file: scs_fifo_if.sv
// Purpose: bundle between the port logic and one FIFO
// Assumes: push and pop are one-cycle pulses in the hclk domain
// Notes: user side fills and drains, store side holds the words
`timescale 1ns/1ps
`default_nettype none
interface scs_fifo_if #(parameter int WIDTH = 16, parameter int DEPTH = 8);
	logic push;
	logic pop;
	logic [WIDTH-1:0] wdata;
	logic [WIDTH-1:0] rdata;
	logic full;
	logic empty;
	logic [$clog2(DEPTH):0] count;
	modport user (output push, output pop, output wdata, input rdata, input full, input empty, input count);
	modport store (input push, input pop, input wdata, output rdata, output full, output empty, output count);
endinterface : scs_fifo_if
`default_nettype wire

// file: scs_pkg.sv
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes: constants live in scs_port_cfg.svh
package scs_pkg;
	typedef enum logic {SCS_IDLE, SCS_SHIFT} scs_state_t;
endpackage : scs_pkg

// file: scs_port.sv
// Purpose: control, data and status of a synchronous serial port, AHB-Lite slave
// Assumes: hclk 100 MHz; serial pins are asynchronous and pass two flip-flops
// Notes: clock idles low, data captured on the rising edge, select active low
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scs_port_cfg.svh"
module scs_port import scs_pkg::*; #(
	parameter int FIFO_DEPTH = `SCS_FIFO_DEPTH
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// serial clock pin
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_n,
	// master-out data pin
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_n,
	// slave-out data pin
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_n,
	// slave select pin, active low
	input wire logic ssel_n_i,
	output logic ssel_n_o,
	output logic ssel_n_oe_n
);
	localparam int W = `SCS_FIFO_WIDTH;

	scs_fifo_if #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) tx_if ();
	scs_fifo_if #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) rx_if ();

	// RULE_21 parameterised FIFOs
	scs_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (.hclk(hclk), .hresetn(hresetn), .f(tx_if.store));
	scs_fifo #(.WIDTH(W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (.hclk(hclk), .hresetn(hresetn), .f(rx_if.store));

	////////////////////////////////////////////////////////////////////////////
	// register bus
	logic loopback_select;
	logic port_enable_bit;
	logic role_select;
	logic slave_output_disable;
	logic [3:0] frame_length_field;
	logic [7:0] half_div;
	logic dp_write;
	logic [31:0] dp_addr;
	logic addr_ok;
	logic rd_data_port;
	logic [31:0] next_hrdata;
	logic [7:0] port_status;
	logic busy;

	assign addr_ok = hsel && hready && (htrans == `SCS_HTRANS_NONSEQ);
	// RULE_12 read pops receive word
	assign rd_data_port = addr_ok && !hwrite && (haddr == `SCS_ADDR_DATA);

	// RULE_14 RULE_15 RULE_16 RULE_17 RULE_18 live flags
	always_comb begin
		port_status = 8'h00;
		port_status[`SCS_STAT_TFE] = tx_if.empty;
		port_status[`SCS_STAT_TNF] = !tx_if.full;
		port_status[`SCS_STAT_RNE] = !rx_if.empty;
		port_status[`SCS_STAT_RFF] = rx_if.full;
		port_status[`SCS_STAT_BSY] = busy;
	end

	always_comb begin
		next_hrdata = 32'h0000_0000;
		unique case (haddr)
			`SCS_ADDR_CTL0: next_hrdata = {16'h0000, half_div, 4'h0, frame_length_field};
			`SCS_ADDR_CTL1: next_hrdata = {28'h000_0000, slave_output_disable, role_select, port_enable_bit,
				loopback_select};
			`SCS_ADDR_DATA: next_hrdata = rx_if.empty ? 32'h0000_0000 : {16'h0000, rx_if.rdata};
			`SCS_ADDR_STAT: next_hrdata = {24'h00_0000, port_status};
			default: next_hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 32'h0000_0000;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			if (hready) begin
				dp_write <= addr_ok && hwrite;
				dp_addr <= haddr;
			end
			if (addr_ok && !hwrite) begin
				hrdata <= next_hrdata;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loopback_select <= 1'b0;
			port_enable_bit <= 1'b0;
			role_select <= 1'b0;
			slave_output_disable <= 1'b0;
			frame_length_field <= `SCS_FLEN_RESET;
			half_div <= `SCS_DIV_RESET;
		end else if (dp_write) begin
			if (dp_addr == `SCS_ADDR_CTL0) begin
				frame_length_field <= hwdata[`SCS_CTL0_FLEN_LSB +: 4];
				half_div <= hwdata[`SCS_CTL0_DIV_LSB +: 8];
			end
			if (dp_addr == `SCS_ADDR_CTL1) begin
				loopback_select <= hwdata[`SCS_CTL1_LOOP];
				port_enable_bit <= hwdata[`SCS_CTL1_EN];
				slave_output_disable <= hwdata[`SCS_CTL1_SOD];
				// RULE_04 role locked while enabled
				if (!port_enable_bit) begin
					role_select <= hwdata[`SCS_CTL1_ROLE];
				end
			end
		end
	end

	// RULE_19 status has no write path
	assign tx_if.push = dp_write && (dp_addr == `SCS_ADDR_DATA);
	assign tx_if.wdata = hwdata[W-1:0];
	assign rx_if.pop = rd_data_port;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	logic sclk_s_d;
	logic sclk_s;
	logic mosi_s;
	logic miso_s;
	logic ssel_s;
	logic ssel_s_d;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_meta <= 4'h8;
			pin_sync <= 4'h8;
			sclk_s_d <= 1'b0;
			ssel_s_d <= 1'b1;
		end else begin
			pin_meta <= {ssel_n_i, miso_i, mosi_i, sclk_i};
			pin_sync <= pin_meta;
			sclk_s_d <= sclk_s;
			ssel_s_d <= ssel_s;
		end
	end
	assign sclk_s = pin_sync[0];
	assign mosi_s = pin_sync[1];
	assign miso_s = pin_sync[2];
	assign ssel_s = pin_sync[3];

	////////////////////////////////////////////////////////////////////////////
	// bit-rate divider for master role
	logic [7:0] div_cnt;
	logic tick;
	logic load;
	assign tick = (div_cnt == 8'h00);

	// restart the half period at each load so the first clock edge keeps full setup
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 8'h00;
		end else if (tick || !port_enable_bit || load) begin
			div_cnt <= (half_div == 8'h00) ? 8'h00 : half_div - 8'h01;
		end else begin
			div_cnt <= div_cnt - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shift engine
	scs_state_t state;
	logic [W-1:0] tx_sh;
	logic [W-1:0] rx_sh;
	logic [3:0] bit_cnt;
	logic [3:0] last_bit;
	logic [W-1:0] len_mask;
	logic reload;
	logic ser_out;
	logic ser_in;
	logic is_master;
	logic is_slave;
	logic start;
	logic rise_ev;
	logic fall_ev;
	logic [W-1:0] new_rx;
	logic [W-1:0] next_tx;

	assign is_master = port_enable_bit && !role_select;
	assign is_slave = port_enable_bit && role_select;
	assign ser_out = tx_sh[W-1];

	// RULE_20 clamp unsupported short codes
	assign last_bit = (frame_length_field < `SCS_FLEN_MIN) ? `SCS_FLEN_MIN : frame_length_field;
	assign len_mask = W'({1'b1, 16'h0000} >> (4'hF - last_bit)) - W'(1);

	// RULE_01 loopback input select
	assign ser_in = loopback_select ? ser_out : (role_select ? mosi_s : miso_s);

	// RULE_10 start at once when idle
	assign start = (state == SCS_IDLE) && ((is_master && !tx_if.empty) || (is_slave && !ssel_s && ssel_s_d));
	assign rise_ev = (state == SCS_SHIFT) && (is_master ? (tick && !sclk_o) : (sclk_s && !sclk_s_d));
	assign fall_ev = (state == SCS_SHIFT) && (is_master ? (tick && sclk_o) : (!sclk_s && sclk_s_d));
	assign load = start || (fall_ev && reload && is_slave);
	assign tx_if.pop = load && !tx_if.empty;
	// RULE_11 left-align the right-justified word
	assign next_tx = tx_if.empty ? 16'h0000 : W'(tx_if.rdata << (4'hF - last_bit));
	// RULE_13 zero above frame length
	assign new_rx = {rx_sh[W-2:0], ser_in} & len_mask;
	assign rx_if.push = rise_ev && (bit_cnt == last_bit);
	assign rx_if.wdata = new_rx;
	assign busy = (state == SCS_SHIFT) || !tx_if.empty;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= SCS_IDLE;
			tx_sh <= 16'h0000;
			rx_sh <= 16'h0000;
			bit_cnt <= 4'h0;
			reload <= 1'b0;
		end else if (!port_enable_bit) begin
			state <= SCS_IDLE;
			reload <= 1'b0;
			bit_cnt <= 4'h0;
		end else if (is_slave && ssel_s) begin
			state <= SCS_IDLE;
			reload <= 1'b0;
			bit_cnt <= 4'h0;
		end else if (load) begin
			state <= SCS_SHIFT;
			tx_sh <= next_tx;
			rx_sh <= 16'h0000;
			bit_cnt <= 4'h0;
			reload <= 1'b0;
		end else if (rise_ev) begin
			rx_sh <= new_rx;
			bit_cnt <= (bit_cnt == last_bit) ? 4'h0 : bit_cnt + 4'h1;
			reload <= (bit_cnt == last_bit);
		end else if (fall_ev) begin
			if (reload) begin
				state <= SCS_IDLE;
				reload <= 1'b0;
			end else begin
				tx_sh <= {tx_sh[W-2:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drivers
	assign mosi_o = tx_sh[W-1];
	assign miso_o = tx_sh[W-1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sclk_o <= 1'b0;
			ssel_n_o <= 1'b1;
			sclk_oe_n <= 1'b1;
			mosi_oe_n <= 1'b1;
			ssel_n_oe_n <= 1'b1;
			miso_oe_n <= 1'b1;
		end else begin
			// RULE_02 RULE_05 RULE_06 drive per role
			sclk_oe_n <= !is_master;
			mosi_oe_n <= !is_master;
			ssel_n_oe_n <= !is_master;
			// RULE_07 slave output disable
			miso_oe_n <= !(is_slave && !slave_output_disable && !ssel_s);
			if (!is_master) begin
				sclk_o <= 1'b0;
				ssel_n_o <= 1'b1;
			end else begin
				if (rise_ev || fall_ev) begin
					sclk_o <= !sclk_o;
				end
				if (start) begin
					ssel_n_o <= 1'b0;
				end else if (fall_ev && reload) begin
					ssel_n_o <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_master_ready;
		(state == SCS_IDLE) && is_master && !tx_if.empty;
	endsequence
	sequence s_frame_opens;
		(state == SCS_SHIFT) && tx_if.count == $past(tx_if.count) - 1'b1 + $past(tx_if.push && !tx_if.full);
	endsequence

	chk_role_locked: assert property ((dp_write && dp_addr == `SCS_ADDR_CTL1 && port_enable_bit) |=> $stable(role_select)) // RULE_04
		else $error("role changed while enabled");
	chk_disabled_quiet: assert property (!port_enable_bit ##1 !port_enable_bit |-> sclk_oe_n && mosi_oe_n && miso_oe_n && ssel_n_oe_n) // RULE_02
		else $error("disabled port drives a pin");
	chk_master_drives: assert property (is_master |=> !sclk_oe_n && !mosi_oe_n && !ssel_n_oe_n && miso_oe_n) // RULE_05
		else $error("master pin drive wrong");
	chk_slave_drives: assert property (is_slave |=> sclk_oe_n && mosi_oe_n && ssel_n_oe_n) // RULE_06
		else $error("slave drives a master pin");
	chk_sod_blocks: assert property ((is_slave && slave_output_disable) |=> miso_oe_n) // RULE_07
		else $error("disabled slave output driven");
	chk_start_now: assert property (s_master_ready |=> s_frame_opens) // RULE_10
		else $error("queued word did not start");
	chk_busy_flag: assert property (!tx_if.empty |-> port_status[`SCS_STAT_BSY]) // RULE_18
		else $error("busy low with queued word");
	chk_rx_justify: assert property (rx_if.push |-> (rx_if.wdata & ~len_mask) == 16'h0000) // RULE_13
		else $error("received bits above frame length");
	chk_loop_input: assert property ((loopback_select && rise_ev && port_enable_bit && !(is_slave && ssel_s)) |=> rx_sh[0] == $past(ser_out)) // RULE_01
		else $error("loopback input not own output");
	chk_read_pops: assert property ((rd_data_port && !rx_if.empty) |=> hrdata[15:0] == $past(rx_if.rdata)) // RULE_12
		else $error("read did not return oldest word");
endmodule : scs_port
`default_nettype wire

// file: scs_port_cfg.svh
// Overview of operation
// RULE_01 - loopback feeds serial output to input
// RULE_02 - disabled port stays off the bus
// RULE_03 - software configures before enabling port
// RULE_04 - role bit writable only while disabled
// RULE_05 - master drives clock, data out, select
// RULE_06 - slave drives only its data output
// RULE_07 - output disable silences slave data line
// RULE_08 - software writes zeros to reserved bits
// RULE_09 - software writes only while space remains
// RULE_10 - idle port starts new word at once
// RULE_11 - software right-justifies short transmit words
// RULE_12 - data read pops oldest received frame
// RULE_13 - short received frames right-justified, zero-filled
// RULE_14 - status bit 0 shows transmit empty
// RULE_15 - status bit 1 shows transmit space
// RULE_16 - status bit 2 shows receive data
// RULE_17 - status bit 3 shows receive full
// RULE_18 - status bit 4 shows line activity; code also sets it while transmit words are queued
// RULE_19 - status register is read-only
// RULE_20 - frame length field selects 4-16 bits
// RULE_21 - both FIFOs default eight 16-bit entries
//
// Purpose: register map, field positions and reset values of the serial port
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes: definitions only
`ifndef SCS_PORT_CFG_SVH
`define SCS_PORT_CFG_SVH

`define SCS_ADDR_CTL0 32'hE006_8000
`define SCS_ADDR_CTL1 32'hE006_8004
`define SCS_ADDR_DATA 32'hE006_8008
`define SCS_ADDR_STAT 32'hE006_800C

`define SCS_CTL1_LOOP 0
`define SCS_CTL1_EN 1
`define SCS_CTL1_ROLE 2
`define SCS_CTL1_SOD 3

`define SCS_CTL0_FLEN_LSB 0
`define SCS_CTL0_DIV_LSB 8
`define SCS_FLEN_RESET 4'h7
`define SCS_FLEN_MIN 4'h3
`define SCS_DIV_RESET 8'h04

`define SCS_STAT_TFE 0
`define SCS_STAT_TNF 1
`define SCS_STAT_RNE 2
`define SCS_STAT_RFF 3
`define SCS_STAT_BSY 4

`define SCS_FIFO_WIDTH 16
`define SCS_FIFO_DEPTH 8
`define SCS_HTRANS_NONSEQ 2'h2

`endif

// file: scs_port_test.sv
// Purpose: self-checking bench of the serial port over AHB-Lite
// Assumes: zero wait states, FIFO depth 4
// Notes: random words from an xorshift seeded with 17647
`timescale 1ns/1ps
`default_nettype none
`include "scs_port_cfg.svh"
module scs_port_test;
	localparam int DEPTH = 4;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd, rnd;
	logic [31:0] seed = 32'h000044EF;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ssel_n_o, ssel_n_oe_n;
	logic p_sclk, p_mosi, p_ssel_n, p_miso, sclk_w, mosi_w, miso_w, ssel_w;
	logic slave_on = 1'b0;
	logic sod_on = 1'b0;
	logic drive_err = 1'b0;
	int fails = 0;
	int compares = 0;
	assign sclk_w = sclk_oe_n ? p_sclk : sclk_o;
	assign mosi_w = mosi_oe_n ? p_mosi : mosi_o;
	assign miso_w = miso_oe_n ? p_miso : miso_o;
	assign ssel_w = ssel_n_oe_n ? p_ssel_n : ssel_n_o;
	scs_port #(.FIFO_DEPTH(DEPTH)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk_i(sclk_w), .sclk_o(sclk_o),
		.sclk_oe_n(sclk_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_i(miso_w),
		.miso_o(miso_o), .miso_oe_n(miso_oe_n), .ssel_n_i(ssel_w), .ssel_n_o(ssel_n_o),
		.ssel_n_oe_n(ssel_n_oe_n));
	scs_spi_peer peer (.hclk(hclk), .dut_master(~ssel_n_oe_n), .sclk(sclk_w), .mosi(mosi_w),
		.ssel_n(ssel_w), .miso(miso_w), .sclk_d(p_sclk), .mosi_d(p_mosi), .ssel_n_d(p_ssel_n),
		.miso_d(p_miso));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (slave_on && {sclk_oe_n, mosi_oe_n, ssel_n_oe_n} !== 3'h7) drive_err <= 1'b1;
		if (sod_on && miso_oe_n !== 1'b1) drive_err <= 1'b1;
	end
	////////////////////////////////////////
	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xorshift
	function automatic logic [15:0] fmask(input int code);
		logic [16:0] t;
		t = (17'h00001 << (code + 1)) - 17'h00001;
		return t[15:0];
	endfunction : fmask
	function automatic logic [31:0] status_of(input int tx, input int rx, input logic busy);
		return {27'h0, busy, rx == DEPTH, rx > 0, tx < DEPTH, tx == 0};
	endfunction : status_of
	task automatic print_verdict();
		$display("counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) begin
				fails++;
				print_verdict();
			end
			@(posedge hclk);
		end
	endtask : wait_ready
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= `SCS_HTRANS_NONSEQ;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		cmp(rd, exp);
	endtask : rdc
	task automatic wait_idle();
		int n;
		n = 0;
		bus(`SCS_ADDR_STAT, 1'b0, 32'h0);
		while (rd[4] !== 1'b0) begin
			n++;
			if (n > 400) begin
				fails++;
				print_verdict();
			end
			bus(`SCS_ADDR_STAT, 1'b0, 32'h0);
		end
	endtask : wait_idle
	////////////////////////////////////////
	initial begin
		logic [15:0] w, r;
		logic [7:0] sent[0:DEPTH];
		logic [7:0] echo[0:DEPTH];
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(`SCS_ADDR_STAT, 32'h3);
		rdc(`SCS_ADDR_CTL1, 32'h0);
		rdc(`SCS_ADDR_DATA, 32'h0);
		wr(`SCS_ADDR_STAT, 32'hFF);
		wr(32'hE006_8040, 32'hFF);
		rdc(`SCS_ADDR_STAT, 32'h3);
		cmp({31'h0, hresp}, 32'h0);
		$display("test reset done");
		wr(`SCS_ADDR_CTL1, 32'h2);
		wr(`SCS_ADDR_CTL1, 32'h6);
		rdc(`SCS_ADDR_CTL1, 32'h2);
		wr(`SCS_ADDR_CTL1, 32'h0);
		wr(`SCS_ADDR_CTL1, 32'h4);
		rdc(`SCS_ADDR_CTL1, 32'h4);
		$display("test role done");
		for (int code = 0; code < 16; code++) begin
			rnd = xorshift();
			w = rnd[15:0] & fmask((code < 3) ? 3 : code);
			wr(`SCS_ADDR_CTL1, 32'h0);
			wr(`SCS_ADDR_CTL0, {16'h0, 8'h04, 4'h0, code[3:0]});
			wr(`SCS_ADDR_CTL1, 32'h3);
			wr(`SCS_ADDR_DATA, {16'h0, w});
			wait_idle();
			rdc(`SCS_ADDR_DATA, {16'h0, w});
			rdc(`SCS_ADDR_STAT, 32'h3);
		end
		$display("test loopback done");
		peer.rxq.delete();
		wr(`SCS_ADDR_CTL1, 32'h0);
		wr(`SCS_ADDR_CTL0, 32'h0407);
		for (int i = 0; i < DEPTH; i++) begin
			rnd = xorshift();
			sent[i] = rnd[7:0];
			echo[i] = rnd[15:8];
			peer.txq.push_back({8'h0, rnd[15:8]});
			rdc(`SCS_ADDR_STAT, status_of(i, 0, i > 0));
			wr(`SCS_ADDR_DATA, {24'h0, sent[i]});
		end
		repeat (20) @(posedge hclk);
		cmp({28'h0, sclk_oe_n, mosi_oe_n, miso_oe_n, ssel_n_oe_n}, 32'hF);
		rdc(`SCS_ADDR_STAT, status_of(DEPTH, 0, 1'b1));
		wr(`SCS_ADDR_CTL1, 32'hA);
		repeat (20) @(posedge hclk);
		cmp({28'h0, sclk_oe_n, mosi_oe_n, miso_oe_n, ssel_n_oe_n}, 32'h2);
		wait_idle();
		rdc(`SCS_ADDR_STAT, status_of(0, DEPTH, 1'b0));
		cmp(peer.rxq.size(), DEPTH);
		for (int i = 0; i < DEPTH; i++) begin
			rdc(`SCS_ADDR_DATA, {24'h0, echo[i]});
			cmp({16'h0, peer.rxq[i]}, {24'h0, sent[i]});
		end
		rdc(`SCS_ADDR_STAT, 32'h3);
		rdc(`SCS_ADDR_DATA, 32'h0);
		$display("test master done");
		peer.txq.delete();
		wr(`SCS_ADDR_CTL1, 32'h0);
		wr(`SCS_ADDR_CTL1, 32'h4);
		wr(`SCS_ADDR_CTL1, 32'h6);
		rnd = xorshift();
		wr(`SCS_ADDR_DATA, {24'h0, rnd[7:0]});
		slave_on <= 1'b1;
		peer.xfer({8'h0, rnd[15:8]}, r);
		@(posedge hclk);
		cmp({16'h0, r}, {24'h0, rnd[7:0]});
		rdc(`SCS_ADDR_DATA, {24'h0, rnd[15:8]});
		wr(`SCS_ADDR_CTL1, 32'hE);
		sod_on <= 1'b1;
		peer.xfer(16'h00A5, r);
		@(posedge hclk);
		sod_on <= 1'b0;
		slave_on <= 1'b0;
		@(posedge hclk);
		cmp({31'h0, drive_err}, 32'h0);
		rdc(`SCS_ADDR_DATA, 32'hA5);
		$display("test slave done");
		print_verdict();
	end
endmodule : scs_port_test
`default_nettype wire

// file: scs_spi_peer.sv
// Purpose: far-side serial device, slave to a master port or master to a slave port
// Assumes: clock idles low, sample on rising, shift on falling, MSB first
// Notes: a released miso line shows a pattern that changes every hclk while ssel_n is high
`timescale 1ns/1ps
`default_nettype none
module scs_spi_peer (
	// clock
	input wire logic hclk,
	// resolved wires
	input wire logic dut_master,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic ssel_n,
	input wire logic miso,
	// peer drives
	output logic sclk_d,
	output logic mosi_d,
	output logic ssel_n_d,
	output logic miso_d
);
	int len = 8;
	logic [15:0] txq[$];
	logic [15:0] rxq[$];
	logic [15:0] sh = 16'h0000;
	logic [15:0] rx = 16'h0000;
	initial begin
		sclk_d = 1'b0;
		mosi_d = 1'b0;
		ssel_n_d = 1'b1;
		miso_d = 1'b0;
	end
	////////////////////////////////////////
	// slave side: an empty queue sends zeros
	always @(negedge ssel_n) if (dut_master) begin
		sh = (txq.size() > 0) ? txq.pop_front() << (16 - len) : 16'h0000;
		miso_d = sh[15];
		rx = 16'h0000;
	end
	always @(posedge sclk) if (dut_master && !ssel_n) rx = {rx[14:0], mosi};
	always @(negedge sclk) if (dut_master && !ssel_n) begin
		sh = sh << 1;
		miso_d = sh[15];
	end
	always @(posedge ssel_n) if (dut_master) rxq.push_back(rx);
	// released line keeps changing
	always @(posedge hclk) if (ssel_n) miso_d <= ~miso_d;
	////////////////////////////////////////
	// master side: 160 ns clock, still outside the frame
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		// step off the clock edge before selecting
		#1;
		r = 16'h0000;
		ssel_n_d = 1'b0;
		for (int i = len - 1; i >= 0; i--) begin
			mosi_d = w[i];
			#80 sclk_d = 1'b1;
			r = {r[14:0], miso};
			#80 sclk_d = 1'b0;
		end
		#80 ssel_n_d = 1'b1;
		mosi_d = ~mosi_d;
	endtask : xfer
endmodule : scs_spi_peer
`default_nettype wire
